// ==== design/rat_top.sv ====
/*
  Remote I2C address translation: serializer address register with
  automatic load after link lock, three remote target entries with their
  aliases, an AHB-Lite register slave and the request translation path.
  Assumes a single AHB-Lite master, a lock level from the link pins, and
  identifier and request strobes from logic on the same clock.
*/
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/100ps
module rat_top
  import rat_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic link_lock,
  input wire logic id_valid,
  input wire logic [6:0] id_addr,
  input wire logic req_valid,
  input wire logic [6:0] req_addr,
  output logic fwd_valid,
  output logic [6:0] fwd_addr,
  output rat_pkg::rat_dest_t fwd_dest,
  output logic [1:0] fwd_entry
);
  import rat_pkg::*;

  // Register state
  logic [6:0] ser_addr_r;
  logic hold_r;
  logic [2:0][7:0] tgt_r;
  logic [2:0][7:0] alias_r;
  logic auto_loaded_r;

  // Lock synchroniser
  logic lock_meta_r;
  logic lock_sync_r;

  // Bus data-phase state
  logic wr_pend_r;
  logic [9:0] wr_idx_r;
  logic acc_ok;
  logic [9:0] acc_idx;
  logic [7:0] rd_val;
  logic auto_load;

  // Views for the translation stage
  logic [2:0][6:0] tgt_addr;
  logic [2:0][6:0] alias_addr;

  // Bus access accepted in address phase; hsize is not checked, words only
  assign acc_ok = hsel && htrans[1] && hready;
  assign acc_idx = haddr[11:2];

  // Link lock crosses from the pins through two flip-flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_meta_r <= 1'b0;
      lock_sync_r <= 1'b0;
    end else begin
      lock_meta_r <= link_lock;
      lock_sync_r <= lock_meta_r;
    end
  end

  // Identifier from the forward channel is taken only with lock and no hold
  assign auto_load = id_valid && lock_sync_r && !hold_r;

  // Write capture in address phase, write in data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_idx_r <= 10'h000;
    end else begin
      wr_pend_r <= acc_ok && hwrite;
      if (acc_ok) begin
        wr_idx_r <= acc_idx;
      end
    end
  end

  // Serializer address register; software write wins over auto load
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ser_addr_r <= RAT_ADDR_RST;
      hold_r <= 1'b0;
    end else if (wr_pend_r && wr_idx_r == RAT_IDX_SER) begin
      ser_addr_r <= rat_addr_field(hwdata[7:0]);
      hold_r <= hwdata[RAT_HOLD_BIT];
    end else if (auto_load) begin
      ser_addr_r <= id_addr;
    end
  end

  // Flag showing the address came from the link
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      auto_loaded_r <= 1'b0;
    end else if (wr_pend_r && wr_idx_r == RAT_IDX_SER) begin
      auto_loaded_r <= 1'b0;
    end else if (auto_load) begin
      auto_loaded_r <= 1'b1;
    end
  end

  // Target and alias entries, full byte kept
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tgt_r <= {RAT_NTGT{RAT_REG_RST}};
      alias_r <= {RAT_NTGT{RAT_REG_RST}};
    end else if (wr_pend_r) begin
      unique case (wr_idx_r)
        RAT_IDX_TGT0: tgt_r[0] <= hwdata[7:0];
        RAT_IDX_TGT1: tgt_r[1] <= hwdata[7:0];
        RAT_IDX_TGT2: tgt_r[2] <= hwdata[7:0];
        RAT_IDX_ALIAS0: alias_r[0] <= hwdata[7:0];
        RAT_IDX_ALIAS1: alias_r[1] <= hwdata[7:0];
        RAT_IDX_ALIAS2: alias_r[2] <= hwdata[7:0];
        default: ;
      endcase
    end
  end

  // Read mux with bypass of a write still in its data phase
  always_comb begin
    rd_val = RAT_REG_RST;
    unique case (acc_idx)
      RAT_IDX_SER: rd_val = {ser_addr_r, hold_r};
      RAT_IDX_TGT0: rd_val = tgt_r[0];
      RAT_IDX_TGT1: rd_val = tgt_r[1];
      RAT_IDX_TGT2: rd_val = tgt_r[2];
      RAT_IDX_ALIAS0: rd_val = alias_r[0];
      RAT_IDX_ALIAS1: rd_val = alias_r[1];
      RAT_IDX_ALIAS2: rd_val = alias_r[2];
      RAT_IDX_STATUS: begin
        rd_val[RAT_ST_LOCK_BIT] = lock_sync_r;
        rd_val[RAT_ST_AUTO_BIT] = auto_loaded_r;
      end
      default: rd_val = RAT_REG_RST;
    endcase
    if (wr_pend_r && wr_idx_r == acc_idx && acc_idx != RAT_IDX_STATUS) begin
      rd_val = hwdata[7:0];
    end
  end

  // Read data registered for the data phase; zero wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= RAT_RDATA_RST;
      hreadyout <= 1'b1;
      hresp <= RAT_HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp <= RAT_HRESP_OKAY;
      if (acc_ok && !hwrite) begin
        hrdata <= {24'h00_0000, rd_val};
      end
    end
  end

  // Address fields for the translation stage
  always_comb begin
    for (int i = 0; i < RAT_NTGT; i++) begin
      tgt_addr[i] = rat_addr_field(tgt_r[i]);
      alias_addr[i] = rat_addr_field(alias_r[i]);
    end
  end

  // Request translation, registered inside the stage
  rat_xlate rat_xlate_inst (
    .hclk(hclk),
    .hresetn(hresetn),
    .req_valid(req_valid),
    .req_addr(req_addr),
    .ser_addr(ser_addr_r),
    .tgt_addr(tgt_addr),
    .alias_addr(alias_addr),
    .fwd_valid_r(fwd_valid),
    .fwd_addr_r(fwd_addr),
    .fwd_dest_r(fwd_dest),
    .fwd_entry_r(fwd_entry)
  );

  // Checks
  property p_ser_reset;
    @(posedge hclk) $rose(hresetn) |-> ser_addr_r == RAT_ADDR_RST && !hold_r;
  endproperty
  a_ser_reset: assert property (p_ser_reset) else $error("serializer addr not zero");

  property p_ser_write;
    @(posedge hclk) disable iff (!hresetn)
    wr_pend_r && wr_idx_r == RAT_IDX_SER
      |=> ser_addr_r == $past(hwdata[7:1]) && hold_r == $past(hwdata[0]);
  endproperty
  a_ser_write: assert property (p_ser_write) else $error("serializer addr write lost");

  property p_zero_blocks;
    @(posedge hclk) disable iff (!hresetn)
    req_valid && ser_addr_r == RAT_ADDR_RST |=> fwd_dest != RAT_DEST_SER;
  endproperty
  a_zero_blocks: assert property (p_zero_blocks) else $error("zero serializer addr used");

  property p_auto_load;
    @(posedge hclk) disable iff (!hresetn)
    id_valid && lock_sync_r && !hold_r && !(wr_pend_r && wr_idx_r == RAT_IDX_SER)
      |=> ser_addr_r == $past(id_addr) && auto_loaded_r;
  endproperty
  a_auto_load: assert property (p_auto_load) else $error("identifier not loaded after lock");

  property p_no_load_unlocked;
    @(posedge hclk) disable iff (!hresetn)
    !lock_sync_r && !(wr_pend_r && wr_idx_r == RAT_IDX_SER) |=> $stable(ser_addr_r);
  endproperty
  a_no_load_unlocked: assert property (p_no_load_unlocked) else $error("load without lock");

  property p_hold_freezes;
    @(posedge hclk) disable iff (!hresetn)
    hold_r && !(wr_pend_r && wr_idx_r == RAT_IDX_SER) |=> $stable(ser_addr_r);
  endproperty
  a_hold_freezes: assert property (p_hold_freezes) else $error("held addr changed");

  property p_tgt_readback;
    @(posedge hclk) disable iff (!hresetn)
    wr_pend_r && wr_idx_r == RAT_IDX_TGT1 ##1 acc_ok && !hwrite && acc_idx == RAT_IDX_TGT1
      && !wr_pend_r |=> hrdata[7:0] == tgt_r[1];
  endproperty
  a_tgt_readback: assert property (p_tgt_readback) else $error("target readback wrong");

  property p_tgt_map;
    @(posedge hclk) disable iff (!hresetn)
    req_valid && rat_hit(req_addr, alias_addr[2]) && !rat_hit(req_addr, alias_addr[1])
      && !rat_hit(req_addr, alias_addr[0]) && !rat_hit(req_addr, ser_addr_r)
      |=> fwd_valid && fwd_entry == 2'd2 && fwd_addr == $past(tgt_addr[2]);
  endproperty
  a_tgt_map: assert property (p_tgt_map) else $error("alias 2 not remapped");

  property p_fwd_pulse;
    @(posedge hclk) disable iff (!hresetn)
    fwd_valid |-> $past(req_valid);
  endproperty
  a_fwd_pulse: assert property (p_fwd_pulse) else $error("forward without request");

  // Further register and routing checks
  property p_tgt_write;
    @(posedge hclk) disable iff (!hresetn)
    wr_pend_r && wr_idx_r == RAT_IDX_TGT0 |=> tgt_r[0] == $past(hwdata[7:0]);
  endproperty
  a_tgt_write: assert property (p_tgt_write) else $error("target entry write lost");

  property p_tgt_reset;
    @(posedge hclk) $rose(hresetn) |-> tgt_r == {RAT_NTGT{RAT_REG_RST}};
  endproperty
  a_tgt_reset: assert property (p_tgt_reset) else $error("target entry not zero");

  property p_ser_fwd;
    @(posedge hclk) disable iff (!hresetn)
    req_valid && rat_hit(req_addr, ser_addr_r)
      |=> fwd_dest == RAT_DEST_SER && fwd_addr == $past(ser_addr_r);
  endproperty
  a_ser_fwd: assert property (p_ser_fwd) else $error("serializer request misrouted");

  // Address zero can never hit: zero entries are disabled
  property p_zero_req_drop;
    @(posedge hclk) disable iff (!hresetn)
    req_valid && req_addr == RAT_ADDR_RST |=> fwd_dest == RAT_DEST_NONE;
  endproperty
  a_zero_req_drop: assert property (p_zero_req_drop) else $error("zero address matched");

  property p_alias1_map;
    @(posedge hclk) disable iff (!hresetn)
    req_valid && rat_hit(req_addr, alias_addr[1]) && !rat_hit(req_addr, alias_addr[0])
      && !rat_hit(req_addr, ser_addr_r)
      |=> fwd_dest == RAT_DEST_TGT && fwd_entry == 2'd1 && fwd_addr == $past(tgt_addr[1]);
  endproperty
  a_alias1_map: assert property (p_alias1_map) else $error("alias 1 not remapped");

  // Scenario covers
  c_auto_load: cover property (@(posedge hclk) disable iff (!hresetn) auto_load ##1 req_valid);
  c_alias_hit: cover property (@(posedge hclk) disable iff (!hresetn)
    fwd_valid && fwd_dest == RAT_DEST_TGT);
  c_hold_block: cover property (@(posedge hclk) disable iff (!hresetn)
    id_valid && lock_sync_r && hold_r);
  c_drop: cover property (@(posedge hclk) disable iff (!hresetn)
    fwd_valid && fwd_dest == RAT_DEST_NONE);
  c_ser_fwd: cover property (@(posedge hclk) disable iff (!hresetn)
    fwd_valid && fwd_dest == RAT_DEST_SER);

endmodule

// ==== design/rat_pkg.sv ====
/*
  Shared constants and types of the remote address translation block:
  register indices, field positions, reset values and destination codes.
  Assumes the register bus is AHB-Lite with 32-bit data, one word a register.
*/
package rat_pkg;

  // Address width of an I2C target
  localparam int RAT_AW = 7;
  // Number of remote target entries
  localparam int RAT_NTGT = 3;
  // Register indices; byte address is four times the index
  localparam logic [9:0] RAT_IDX_SER = 10'h007;
  localparam logic [9:0] RAT_IDX_TGT0 = 10'h008;
  localparam logic [9:0] RAT_IDX_TGT1 = 10'h009;
  localparam logic [9:0] RAT_IDX_TGT2 = 10'h00a;
  localparam logic [9:0] RAT_IDX_ALIAS0 = 10'h010;
  localparam logic [9:0] RAT_IDX_ALIAS1 = 10'h011;
  localparam logic [9:0] RAT_IDX_ALIAS2 = 10'h012;
  localparam logic [9:0] RAT_IDX_STATUS = 10'h013;
  // Field positions inside an 8-bit register
  localparam int RAT_ADDR_LSB = 1;
  localparam int RAT_ADDR_MSB = 7;
  localparam int RAT_HOLD_BIT = 0;
  localparam int RAT_ST_LOCK_BIT = 0;
  localparam int RAT_ST_AUTO_BIT = 1;
  // Reset values
  localparam logic [7:0] RAT_REG_RST = 8'h00;
  localparam logic [6:0] RAT_ADDR_RST = 7'h00;
  // Bus codes
  localparam logic RAT_HRESP_OKAY = 1'b0;
  localparam logic [31:0] RAT_RDATA_RST = 32'h0000_0000;

  // Where a request was sent
  typedef enum logic [1:0] {
    RAT_DEST_NONE,
    RAT_DEST_SER,
    RAT_DEST_TGT
  } rat_dest_t;

  // Address field of a register image
  function automatic logic [6:0] rat_addr_field(input logic [7:0] v);
    return v[RAT_ADDR_MSB:RAT_ADDR_LSB];
  endfunction

  // Full 7-bit match against an enabled (nonzero) entry
  function automatic logic rat_hit(input logic [6:0] a, input logic [6:0] ref_a);
    return (ref_a != RAT_ADDR_RST) && (a == ref_a);
  endfunction

endpackage

// ==== design/rat_xlate.sv ====
/*
  Address translation stage: maps a request address onto the serializer
  or onto the physical address of a remote target entry, one cycle later.
  Assumes request and tables come from logic on the same clock.
*/
`timescale 1ns/100ps
module rat_xlate
  import rat_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic req_valid,
  input wire logic [6:0] req_addr,
  input wire logic [6:0] ser_addr,
  input wire logic [2:0][6:0] tgt_addr,
  input wire logic [2:0][6:0] alias_addr,
  output logic fwd_valid_r,
  output logic [6:0] fwd_addr_r,
  output rat_pkg::rat_dest_t fwd_dest_r,
  output logic [1:0] fwd_entry_r
);

  logic [6:0] addr_nxt;
  rat_dest_t dest_nxt;
  logic [1:0] entry_nxt;

  // Serializer first, then lowest matching alias entry
  always_comb begin
    addr_nxt = RAT_ADDR_RST;
    dest_nxt = RAT_DEST_NONE;
    entry_nxt = 2'd0;
    for (int i = RAT_NTGT - 1; i >= 0; i--) begin
      if (rat_hit(req_addr, alias_addr[i])) begin
        addr_nxt = tgt_addr[i];
        dest_nxt = RAT_DEST_TGT;
        entry_nxt = 2'(i);
      end
    end
    if (rat_hit(req_addr, ser_addr)) begin
      addr_nxt = ser_addr;
      dest_nxt = RAT_DEST_SER;
      entry_nxt = 2'd0;
    end
  end

  // Result register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fwd_valid_r <= 1'b0;
      fwd_addr_r <= RAT_ADDR_RST;
      fwd_dest_r <= RAT_DEST_NONE;
      fwd_entry_r <= 2'd0;
    end else begin
      fwd_valid_r <= req_valid;
      if (req_valid) begin
        fwd_addr_r <= addr_nxt;
        fwd_dest_r <= dest_nxt;
        fwd_entry_r <= entry_nxt;
      end
    end
  end

  property p_alias_maps;
    @(posedge hclk) disable iff (!hresetn)
    req_valid && rat_hit(req_addr, alias_addr[0]) && !rat_hit(req_addr, ser_addr)
      |=> fwd_dest_r == RAT_DEST_TGT && fwd_addr_r == $past(tgt_addr[0]);
  endproperty
  a_alias_maps: assert property (p_alias_maps) else $error("alias 0 not remapped");

  property p_no_match_drop;
    @(posedge hclk) disable iff (!hresetn)
    req_valid && !rat_hit(req_addr, ser_addr) && !rat_hit(req_addr, alias_addr[0])
      && !rat_hit(req_addr, alias_addr[1]) && !rat_hit(req_addr, alias_addr[2])
      |=> fwd_valid_r && fwd_dest_r == RAT_DEST_NONE;
  endproperty
  a_no_match_drop: assert property (p_no_match_drop) else $error("unmatched forwarded");

endmodule

// ==== test/rat_far_model.sv ====
/*
  Far-side model: lock level and identifier strobe of the serializer,
  request strobes of the local I2C controller.
  Assumes one shared clock; tasks are entered just after a rising edge.
*/
`timescale 1ns/100ps
module rat_far_model (
  input wire logic hclk,
  output logic link_lock,
  output logic id_valid,
  output logic [6:0] id_addr,
  output logic req_valid,
  output logic [6:0] req_addr
);
  // Idle levels from time zero
  initial begin
    link_lock = 1'b0;
    id_valid = 1'b0;
    id_addr = 7'h55;
    req_valid = 1'b0;
    req_addr = 7'h2a;
  end
  // Lock level from the link pins
  task automatic lock(input logic v);
    link_lock <= v;
  endtask
  // Identifier pulse; stale data inverted after the strobe
  task automatic send_id(input logic [6:0] a);
    id_valid <= 1'b1;
    id_addr <= a;
    @(posedge hclk);
    id_valid <= 1'b0;
    id_addr <= ~a;
  endtask
  // Back-to-back request pulses
  task automatic send_reqs(input logic [6:0] l [4], input int n);
    for (int i = 0; i < n; i++) begin
      req_valid <= 1'b1;
      req_addr <= l[i];
      @(posedge hclk);
    end
    req_valid <= 1'b0;
    req_addr <= ~l[n-1];
  endtask
endmodule

// ==== test/rat_top_bench.sv ====
/*
  Self-checking bench: AHB-Lite register master, far-side model, queued
  expectations compared by a watcher on the falling edge.
  Assumes the zero-wait slave and one-cycle request latency of the top.
*/
`timescale 1ns/100ps
module rat_top_bench;
  import rat_pkg::*;
  logic hclk = 1'b0;
  logic hresetn, hsel, hwrite, hreadyout, hresp, rdy_s, rd_dph;
  logic link_lock, id_valid, req_valid, fwd_valid;
  logic [11:0] haddr;
  logic [1:0] htrans, fwd_entry;
  logic [31:0] hwdata, hrdata, seed, exp_w;
  logic [6:0] id_addr, req_addr, fwd_addr, ser_m;
  rat_dest_t fwd_dest;
  logic [6:0] tgt_m [3];
  logic [6:0] ali_m [3];
  logic [31:0] exp_rd [$];
  logic [10:0] exp_fwd [$];
  int err_total, num_checks, cyc;

  rat_top rat_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link_lock(link_lock),
    .id_valid(id_valid), .id_addr(id_addr), .req_valid(req_valid), .req_addr(req_addr),
    .fwd_valid(fwd_valid), .fwd_addr(fwd_addr), .fwd_dest(fwd_dest), .fwd_entry(fwd_entry));
  rat_far_model rat_far_model_inst (.hclk(hclk), .link_lock(link_lock), .id_valid(id_valid),
    .id_addr(id_addr), .req_valid(req_valid), .req_addr(req_addr));

  // Clock, 40 ns period
  always #20 hclk = ~hclk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h0040_0007 : 32'h0);
  endfunction

  // Expected translation from the bench's own register image
  function automatic logic [10:0] xlate(input logic [6:0] a);
    if (ser_m != 7'h00 && a == ser_m) return {RAT_DEST_SER, 2'h0, ser_m};
    for (int i = 0; i < 3; i++) begin
      if (ali_m[i] != 7'h00 && a == ali_m[i]) return {RAT_DEST_TGT, 2'(i), tgt_m[i]};
    end
    return {RAT_DEST_NONE, 2'h0, 7'h00};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want) begin
      err_total++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  // One AHB single transfer; for reads d is the expected word
  task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (rdy_s !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    rd_dph <= !w;
    if (!w) exp_rd.push_back(d);
    do @(posedge hclk); while (rdy_s !== 1'b1);
    rd_dph <= 1'b0;
  endtask

  // Requests with their expectations noted first
  task automatic reqs(input logic [6:0] l [4]);
    for (int i = 0; i < 4; i++) exp_fwd.push_back(xlate(l[i]));
    rat_far_model_inst.send_reqs(l, 4);
    repeat (2) @(posedge hclk);
  endtask

  // Watcher: compares results against the oldest note
  always @(negedge hclk) begin
    rdy_s = hreadyout;
    if (rd_dph === 1'b1 && hreadyout === 1'b1) begin
      check(hrdata, exp_rd.size() ? exp_rd.pop_front() : '1);
      check({31'h0, hresp}, 32'h0);
    end
    if (fwd_valid === 1'b1) begin
      exp_w = exp_fwd.size() ? {21'h0, exp_fwd.pop_front()} : '1;
      check({21'h0, fwd_dest, fwd_entry, fwd_addr}, exp_w);
    end
  end

  // Hang guard
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      $display("unexpected at %0t: timeout", $time);
      final_report();
    end
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = 12'h000;
    hwrite = 1'b0;
    hwdata = 32'h0;
    rd_dph = 1'b0;
    ser_m = 7'h00;
    ali_m = '{7'h00, 7'h00, 7'h00};
    err_total = 0;
    num_checks = 0;
    cyc = 0;
    seed = 32'd88323;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset values and an unmapped word
    for (int i = 0; i < 5; i++) ahb(1'b0, 12'(28 + 4 * i), 32'h0);
    done("reset");
    // Target entries with random data; upper bits dropped
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      tgt_m[i] = seed[7:1];
      ahb(1'b1, 12'(32 + 4 * i), seed);
      ahb(1'b0, 12'(32 + 4 * i), {24'h0, seed[7:0]});
    end
    ahb(1'b1, 12'h030, 32'hff);
    ahb(1'b0, 12'h030, 32'h0);
    done("targets");
    // Identifier while unlocked is ignored; zero address blocks
    rat_far_model_inst.send_id(7'h2a);
    ahb(1'b0, 12'h01c, 32'h0);
    ahb(1'b0, 12'h04c, 32'h0);
    reqs('{7'h00, seed[6:0], 7'h2a, 7'h7f});
    done("blocked");
    // Lock, automatic load, alias translation
    rat_far_model_inst.lock(1'b1);
    repeat (4) @(posedge hclk);
    rat_far_model_inst.send_id(7'h35);
    ser_m = 7'h35;
    ahb(1'b0, 12'h01c, 32'h6a);
    ahb(1'b0, 12'h04c, 32'h3);
    for (int i = 0; i < 3; i++) begin
      ali_m[i] = 7'(8'h50 + i);
      ahb(1'b1, 12'(64 + 4 * i), {24'h0, ali_m[i], 1'b0});
    end
    reqs('{7'h35, 7'h50, 7'h51, 7'h52});
    seed = lfsr(seed);
    reqs('{7'h53, 7'h34, 7'h70, seed[6:0]});
    done("translate");
    // Software address with hold set survives an identifier
    ahb(1'b1, 12'h01c, 32'h47);
    ser_m = 7'h23;
    rat_far_model_inst.send_id(7'h11);
    ahb(1'b0, 12'h01c, 32'h47);
    ahb(1'b0, 12'h04c, 32'h1);
    reqs('{7'h23, 7'h11, 7'h35, 7'h51});
    ahb(1'b1, 12'h01c, 32'h01);
    ser_m = 7'h00;
    reqs('{7'h23, 7'h00, 7'h52, 7'h01});
    done("hold");
    check(32'(exp_fwd.size() + exp_rd.size()), 32'h0);
    final_report();
  end
endmodule
